/* dv/csms_seq_sva.sv */
// checker for the measurement sequencer ports
// assumes it is bound onto csms_seq with matching parameters
`timescale 1ns/1ps
`default_nettype none
module csms_seq_sva #(
    parameter int WIDTH = 16,
    parameter int CONV_BASE_CYC = 64
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] state_control_register,
    input wire logic [7:0] setup_register_one,
    input wire logic [7:0] setup_register_three,
    input wire logic [WIDTH-1:0] result_channel_one,
    input wire logic [WIDTH-1:0] result_channel_two,
    input wire logic [WIDTH-1:0] result_channel_three,
    input wire logic [WIDTH-1:0] result_temp,
    input wire logic [7:0] status,
    input wire logic eoc_ready,
    input wire logic measure_state,
    input wire logic power_down
);
    // ----------------
    // low time counter
    // ----------------
    logic [31:0] low_r;
    logic [31:0] low_nxt;
    always_comb begin
        low_nxt = eoc_ready ? 32'h0 : low_r + 32'h1;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            low_r <= 32'h0;
        end else begin
            low_r <= low_nxt;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ----------
    // properties
    // ----------
    property p_meas_code;
        measure_state == (state_control_register[2:0] == 3'h3);
    endproperty
    a_meas_code: assert property (p_meas_code) else $error("measure flag differs from state field");
    property p_res_zero;
        !measure_state |-> (result_channel_one | result_channel_two | result_channel_three | result_temp) == '0;
    endproperty
    a_res_zero: assert property (p_res_zero) else $error("results visible outside measure");
    property p_no_conv;
        !measure_state && !$past(measure_state) |-> eoc_ready;
    endproperty
    a_no_conv: assert property (p_no_conv) else $error("conversion outside measure");
    property p_clear;
        $fell(measure_state) |-> ##1 (status == 8'h00 && eoc_ready);
    endproperty
    a_clear: assert property (p_clear) else $error("leaving measure did not clear");
    property p_conv_len;
        $rose(eoc_ready) && measure_state && status != $past(status)
            |-> low_r == 32'((CONV_BASE_CYC << setup_register_one[3:0]) + 1);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_status;
        measure_state && status != $past(status) |-> $rose(eoc_ready) && status == $past(status) + 8'h01;
    endproperty
    a_status: assert property (p_status) else $error("status moved without conversion end");
    property p_hold;
        measure_state && $past(measure_state) && eoc_ready && $past(eoc_ready)
            |-> $stable(result_channel_one) && $stable(result_temp);
    endproperty
    a_hold: assert property (p_hold) else $error("results changed while valid");
    property p_setup_lock;
        measure_state && $past(measure_state) |-> $stable(setup_register_one) && $stable(setup_register_three);
    endproperty
    a_setup_lock: assert property (p_setup_lock) else $error("setup changed in measure");
    property p_single;
        $rose(eoc_ready) && measure_state && setup_register_three[7:6] == 2'h1 |-> ##[0:1] state_control_register == 8'h03;
    endproperty
    a_single: assert property (p_single) else $error("start bit not cleared");
    property p_wake;
        $fell(power_down) |-> eoc_ready [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("conversion before startup");
endmodule
bind csms_seq csms_seq_sva #(.WIDTH(WIDTH), .CONV_BASE_CYC(CONV_BASE_CYC)) u_sva (.mclk(mclk), .rst_b(rst_b),
    .state_control_register(state_control_register), .setup_register_one(setup_register_one),
    .setup_register_three(setup_register_three), .result_channel_one(result_channel_one),
    .result_channel_two(result_channel_two), .result_channel_three(result_channel_three),
    .result_temp(result_temp), .status(status), .eoc_ready(eoc_ready), .measure_state(measure_state),
    .power_down(power_down));
`default_nettype wire

/* dv/csms_trig_src.sv */
// trigger source at the far side of the trigger pin
// assumes trig_clk is the link clock made by the bench
`timescale 1ns/1ps
`default_nettype none
module csms_trig_src (
    input wire logic trig_clk,
    output logic pin
);
    initial begin
        pin = 1'h1;
    end
    // low pulse of w link clocks, never shorter than three
    task automatic fire(input int w);
        @(posedge trig_clk);
        pin <= 1'h0;
        repeat ((w < 3) ? 3 : w) @(posedge trig_clk);
        pin <= 1'h1;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the measurement sequencer
// assumes csms_seq, its checker and the trigger source are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, trig_clk, rst_b, trig_pin, wr_stop, eoc, meas, pd;
    logic [1:0] wr_sel;
    logic [7:0] wr_data, scr, s1, s2, s3, pause, status, rnd;
    logic [47:0] sample_in;
    logic [15:0] temp_in, r1, r2, r3, rt;
    logic [3:0] len;
    int err_total, checked, cyc, seed, n;
    csms_trig_src u_src (.trig_clk(trig_clk), .pin(trig_pin));
    csms_seq #(.STARTUP_CYC(20), .CONV_BASE_CYC(4)) dut (.mclk(mclk), .rst_b(rst_b),
        .trig_clk(trig_clk), .external_trigger_pin(trig_pin), .wr_stop(wr_stop), .wr_sel(wr_sel),
        .wr_data(wr_data), .sample_in(sample_in), .temp_in(temp_in), .state_control_register(scr),
        .setup_register_one(s1), .setup_register_two(s2), .setup_register_three(s3),
        .inter_conversion_pause(pause), .result_channel_one(r1), .result_channel_two(r2),
        .result_channel_three(r3), .result_temp(rt), .status(status), .eoc_ready(eoc),
        .measure_state(meas), .power_down(pd));
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        trig_clk = 1'h0;
        #7;
        forever #16 trig_clk = ~trig_clk;
    end
    // -----
    // tasks
    // -----
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge mclk);
        wr_stop <= 1'h1;
        wr_sel <= sel;
        wr_data <= d;
        @(posedge mclk);
        wr_stop <= 1'h0;
        #1;
    endtask
    task automatic wait_eoc(input logic lvl, input int lim, output int c);
        c = 0;
        while (eoc !== lvl && c < lim) begin
            @(posedge mclk);
            #1;
            c++;
        end
        chk("eoc_level", eoc, lvl);
    endtask
    task automatic conv(input int lim);
        int c;
        wait_eoc(1'h0, lim, c);
        wait_eoc(1'h1, 2000, c);
        chk("conv_len", c, (4 << len) + 1);
        chk("res_one", r1, sample_in[15:0]);
        chk("res_two", r2, sample_in[31:16]);
        chk("res_three", r3, sample_in[47:32]);
        chk("res_temp", rt, temp_in);
    endtask
    task automatic new_samples;
        @(posedge mclk);
        sample_in <= {16'($random(seed)), 16'($random(seed)), 16'($random(seed))};
        temp_in <= 16'($random(seed));
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            $display("ERROR cycle_limit expected %0d seen %0d", 39999, cyc);
            give_verdict();
        end
    end
    // ---------
    // main flow
    // ---------
    initial begin
        seed = 32'h2beebb5e;
        {err_total, checked, cyc} = '0;
        {rst_b, wr_stop, wr_sel, wr_data} = '0;
        sample_in = {$random(seed), 16'($random(seed))};
        temp_in = 16'($random(seed));
        len = 4'($unsigned($random(seed)) % 3);
        repeat (16) @(posedge mclk);
        rst_b <= 1'h1;
        #1;
        chk("scr_reset", scr, 8'h40);
        chk("pd_reset", pd, 1'h1);
        chk("eoc_reset", eoc, 1'h1);
        $display("test reset done");
        wr(2'h0, 8'h02);
        chk("meas_cfg", meas, 1'h0);
        wr(2'h1, {4'h0, len});
        wr(2'h3, 8'h40);
        rnd = 8'($random(seed));
        wr(2'h2, rnd);
        @(posedge mclk);
        wr_data <= ~rnd;
        repeat (2) @(posedge mclk);
        #1;
        chk("setup_two", s2, rnd);
        chk("setup_one", s1, {4'h0, len});
        chk("res_cfg", r1, 16'h0);
        repeat (30) @(posedge mclk);
        #1;
        chk("pd_awake", pd, 1'h0);
        new_samples();
        wr(2'h0, 8'h83);
        chk("meas_on", meas, 1'h1);
        conv(10);
        @(posedge mclk);
        #1;
        chk("scr_clear", scr, 8'h03);
        wr(2'h1, 8'h0F);
        chk("setup_lock", s1, {4'h0, len});
        new_samples();
        wr(2'h0, 8'h80);
        conv(10);
        chk("status_two", status, 8'h02);
        wr(2'h0, 8'h80);
        wait_eoc(1'h0, 10, n);
        wr(2'h0, 8'h02);
        repeat (2) @(posedge mclk);
        #1;
        chk("abort_eoc", eoc, 1'h1);
        chk("abort_status", status, 8'h00);
        $display("test single done");
        wr(2'h3, 8'h01);
        chk("pause_reg", pause, 8'h01);
        new_samples();
        wr(2'h0, 8'h83);
        conv(10);
        wait_eoc(1'h0, 400, n);
        chk("pause_gap", n >= 200 && n <= 204, 1'h1);
        conv(1);
        wr(2'h0, 8'h03);
        repeat (500) @(posedge mclk);
        #1;
        chk("stopped", {eoc, status}, {1'h1, 8'h02});
        $display("test repeat done");
        wr(2'h0, 8'h02);
        wr(2'h3, 8'h80);
        wr(2'h0, 8'h03);
        u_src.fire(4);
        repeat (20) @(posedge mclk);
        #1;
        chk("no_start", eoc, 1'h1);
        wr(2'h0, 8'h80);
        new_samples();
        fork
            u_src.fire(3);
            conv(12);
        join
        u_src.fire(4);
        repeat (20) @(posedge mclk);
        #1;
        chk("pause_ignore", eoc, 1'h1);
        repeat (25700) @(posedge mclk);
        fork
            u_src.fire(5);
            conv(12);
        join
        wr(2'h0, 8'h02);
        wr(2'h3, 8'hC0);
        wr(2'h0, 8'h83);
        fork
            u_src.fire(3 + ($unsigned($random(seed)) % 3));
            conv(12);
        join
        $display("test trigger done");
        give_verdict();
    end
endmodule
`default_nettype wire

/* inc/csms_cfg.svh */
// constants for the colour sensor measurement sequencer
// assumes mclk at 25 MHz and a link clock from the trigger side
//
// Overview of operation
// - at conversion end each optical channel value lands in its own result register
// - a temperature value is captured alongside the optical channels at conversion end
// - end-of-conversion flag low during conversion, high after it with valid results
// - operating-state field in bits 2..0 of state control selects config or measure
// - after reset stay powered down but keep accepting register writes
// - clearing power-down starts up in the state the operating field selects
// - config state: setup registers open, no measurement, results hidden
// - measure state: conversions and results open, setup registers closed
// - measure to config at once stops conversion and clears results and status
// - four measurement kinds chosen by the kind field of setup register three
// - repeating, edge-started, edge-bounded modes insert the pause between conversions
// - writes take effect only once the whole transfer ends with stop
// - repeating mode start bit ends power-down then converts repeatedly with the pause between
// - repeating mode runs until the host clears the start bit
// - in measure state 83h starts repeating conversion and 03h aborts it
// - pause programmable in 8 us steps up to 2040 us; here it takes the setup register three write, kind bits included
// - conversion length comes from the length field of setup register one
// - single-shot: one conversion per start, then the start bit self clears
// - 83h from config enters measure and starts; later 80h restarts, 000b is no change
// - edge-started mode: falling trigger edge starts conversion only with start bit set
// - edge-started mode ignores trigger edges during the pause
// - start within three clocks of falling trigger, pulses of three clocks recognised; here start comes three link clocks then three mclk edges later
// - leaving power-down waits a startup delay of at most 2 ms
// - code 010b is config and 011b is measure; 02h after reset wakes to config
`ifndef CSMS_CFG_SVH
`define CSMS_CFG_SVH
`define CSMS_SCR_START_BIT 7
`define CSMS_SCR_PD_BIT 6
`define CSMS_OPS_NOP 3'h0
`define CSMS_OPS_CONFIG 3'h2
`define CSMS_OPS_MEASURE 3'h3
`define CSMS_SCR_RESET 8'h40
`define CSMS_KIND_LO 6
`define CSMS_KIND_HI 7
`define CSMS_MCLK_KHZ 25000
`define CSMS_PAUSE_STEP_NS 8000
`define CSMS_PAUSE_STEP_CYC ((`CSMS_PAUSE_STEP_NS * `CSMS_MCLK_KHZ) / 1000000)
`define CSMS_STARTUP_US 2000
`define CSMS_STARTUP_CYC ((`CSMS_STARTUP_US * `CSMS_MCLK_KHZ) / 1000)
`define CSMS_CONV_BASE_CYC 64
`endif

/* inc/csms_pkg.sv */
// types for the colour sensor measurement sequencer
// assumes csms_cfg.svh is compiled alongside
package csms_pkg;
    typedef enum logic [1:0] {
        CSMS_REPEAT,
        CSMS_SINGLE,
        CSMS_EDGE_START,
        CSMS_EDGE_BOUND
    } csms_kind_t;
    typedef enum logic [2:0] {
        CSMS_ST_PDOWN,
        CSMS_ST_WAKE,
        CSMS_ST_IDLE,
        CSMS_ST_CONV,
        CSMS_ST_PAUSE
    } csms_state_t;
endpackage

/* verilog/csms_channel.sv */
// one conversion channel: registers the sample while running and holds the result
// assumes sample input is a level from the analog front end model
`timescale 1ns/1ps
`default_nettype none
module csms_channel #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic running,
    input wire logic capture,
    input wire logic [WIDTH-1:0] sample,
    output logic [WIDTH-1:0] result
);
    typedef struct packed {
        logic [WIDTH-1:0] acc;
        logic [WIDTH-1:0] res;
    } csms_ch_t;
    csms_ch_t ch_r, ch_nxt;
    always_comb begin
        ch_nxt = ch_r;
        if (clear || !running) begin
            ch_nxt.acc = '0;
        end else begin
            ch_nxt.acc = sample;
        end
        if (clear) begin
            ch_nxt.res = '0;
        end else if (capture) begin
            ch_nxt.res = ch_r.acc;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ch_r <= '0;
        end else begin
            ch_r <= ch_nxt;
        end
    end
    assign result = ch_r.res;
endmodule
`default_nettype wire

/* verilog/csms_seq.sv */
// measurement sequencer top: state control, setup registers, modes, results
// assumes writes arrive as one-cycle strobes on mclk after the bus stop
`timescale 1ns/1ps
`default_nettype none
`include "csms_cfg.svh"
module csms_seq #(
    parameter int WIDTH = 16,
    parameter int STARTUP_CYC = `CSMS_STARTUP_CYC,
    parameter int CONV_BASE_CYC = `CSMS_CONV_BASE_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic trig_clk,
    input wire logic external_trigger_pin,
    input wire logic wr_stop,
    input wire logic [1:0] wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic [3*WIDTH-1:0] sample_in,
    input wire logic [WIDTH-1:0] temp_in,
    output logic [7:0] state_control_register,
    output logic [7:0] setup_register_one,
    output logic [7:0] setup_register_two,
    output logic [7:0] setup_register_three,
    output logic [7:0] inter_conversion_pause,
    output logic [WIDTH-1:0] result_channel_one,
    output logic [WIDTH-1:0] result_channel_two,
    output logic [WIDTH-1:0] result_channel_three,
    output logic [WIDTH-1:0] result_temp,
    output logic [7:0] status,
    output logic eoc_ready,
    output logic measure_state,
    output logic power_down
);
    typedef struct packed {
        logic [7:0] scr;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] pause;
        csms_pkg::csms_state_t st;
        logic [31:0] cnt;
        logic ready;
        logic [WIDTH-1:0] temp;
        logic [7:0] stat;
    } csms_top_t;
    csms_top_t q_r, q_nxt;
    logic trig_fall;
    logic in_meas;
    logic cap;
    logic clr;
    logic run;
    logic [WIDTH-1:0] res [3];
    csms_pkg::csms_kind_t kind;
    logic [31:0] conv_len;
    logic [31:0] pause_len;
    logic [2:0] ops;
    logic go_bit;
    logic start_ok;

    // ----------------------------------------
    // trigger crossing and channel slices
    // ----------------------------------------
    csms_trig_sync u_trig (
        .trig_clk(trig_clk),
        .mclk(mclk),
        .rst_b(rst_b),
        .external_trigger_pin(external_trigger_pin),
        .fall_pulse(trig_fall)
    );
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ch
            csms_channel #(.WIDTH(WIDTH)) u_ch (
                .mclk(mclk),
                .rst_b(rst_b),
                .clear(clr),
                .running(run),
                .capture(cap),
                .sample(sample_in[gi*WIDTH +: WIDTH]),
                .result(res[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // decoded fields
    // ----------------------------------------
    assign ops = q_r.scr[2:0];
    assign in_meas = (ops == `CSMS_OPS_MEASURE);
    assign go_bit = q_r.scr[`CSMS_SCR_START_BIT];
    assign kind = csms_pkg::csms_kind_t'(q_r.s3[`CSMS_KIND_HI:`CSMS_KIND_LO]);
    assign conv_len = 32'(CONV_BASE_CYC) << q_r.s1[3:0];
    assign pause_len = 32'(q_r.pause) * 32'(`CSMS_PAUSE_STEP_CYC);
    assign run = (q_r.st == csms_pkg::CSMS_ST_CONV);
    assign cap = run && (q_r.cnt == 32'h0) && in_meas && go_bit;
    assign clr = !in_meas;
    assign start_ok = (kind == csms_pkg::CSMS_REPEAT || kind == csms_pkg::CSMS_SINGLE) ? 1'b1 : trig_fall;

    // ----------------------------------------
    // sequencer and register writes
    // ----------------------------------------
    always_comb begin
        q_nxt = q_r;
        if (wr_stop) begin
            case (wr_sel)
                2'h0: begin
                    q_nxt.scr[7:3] = wr_data[7:3];
                    if (wr_data[2:0] != `CSMS_OPS_NOP) begin
                        q_nxt.scr[2:0] = wr_data[2:0];
                    end
                end
                2'h1: begin
                    if (!in_meas) begin
                        q_nxt.s1 = wr_data;
                    end
                end
                2'h2: begin
                    if (!in_meas) begin
                        q_nxt.s2 = wr_data;
                    end
                end
                default: begin
                    if (!in_meas) begin
                        q_nxt.s3 = wr_data;
                        q_nxt.pause = wr_data;
                    end
                end
            endcase
        end
        case (q_r.st)
            csms_pkg::CSMS_ST_PDOWN: begin
                q_nxt.ready = 1'b1;
                if (!q_r.scr[`CSMS_SCR_PD_BIT] || (in_meas && go_bit)) begin
                    q_nxt.st = csms_pkg::CSMS_ST_WAKE;
                    q_nxt.cnt = 32'(STARTUP_CYC);
                end
            end
            csms_pkg::CSMS_ST_WAKE: begin
                if (q_r.cnt != 32'h0) begin
                    q_nxt.cnt = q_r.cnt - 32'h1;
                end else begin
                    q_nxt.st = csms_pkg::CSMS_ST_IDLE;
                end
            end
            csms_pkg::CSMS_ST_IDLE: begin
                if (in_meas && go_bit && start_ok) begin
                    q_nxt.st = csms_pkg::CSMS_ST_CONV;
                    q_nxt.cnt = conv_len;
                    q_nxt.ready = 1'b0;
                end else if (q_r.scr[`CSMS_SCR_PD_BIT] && !go_bit) begin
                    q_nxt.st = csms_pkg::CSMS_ST_PDOWN;
                end
            end
            csms_pkg::CSMS_ST_CONV: begin
                if (!in_meas || !go_bit) begin
                    q_nxt.st = csms_pkg::CSMS_ST_IDLE;
                    q_nxt.ready = 1'b1;
                end else if (q_r.cnt != 32'h0) begin
                    q_nxt.cnt = q_r.cnt - 32'h1;
                end else begin
                    q_nxt.ready = 1'b1;
                    q_nxt.temp = temp_in;
                    q_nxt.stat = q_r.stat + 8'h01;
                    if (kind == csms_pkg::CSMS_SINGLE) begin
                        if (!(wr_stop && wr_sel == 2'h0)) begin
                            q_nxt.scr[`CSMS_SCR_START_BIT] = 1'b0;
                        end
                        q_nxt.st = csms_pkg::CSMS_ST_IDLE;
                    end else begin
                        q_nxt.st = csms_pkg::CSMS_ST_PAUSE;
                        q_nxt.cnt = pause_len;
                    end
                end
            end
            csms_pkg::CSMS_ST_PAUSE: begin
                if (!in_meas || !go_bit) begin
                    q_nxt.st = csms_pkg::CSMS_ST_IDLE;
                end else if (q_r.cnt != 32'h0) begin
                    q_nxt.cnt = q_r.cnt - 32'h1;
                end else if (kind == csms_pkg::CSMS_REPEAT) begin
                    q_nxt.st = csms_pkg::CSMS_ST_CONV;
                    q_nxt.cnt = conv_len;
                    q_nxt.ready = 1'b0;
                end else begin
                    q_nxt.st = csms_pkg::CSMS_ST_IDLE;
                end
            end
            default: begin
                q_nxt.st = csms_pkg::CSMS_ST_PDOWN;
            end
        endcase
        if (clr) begin
            q_nxt.temp = '0;
            q_nxt.stat = 8'h00;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q_r <= '0;
            q_r.scr <= `CSMS_SCR_RESET;
            q_r.ready <= 1'b1;
            q_r.st <= csms_pkg::CSMS_ST_PDOWN;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign state_control_register = q_r.scr;
    assign setup_register_one = q_r.s1;
    assign setup_register_two = q_r.s2;
    assign setup_register_three = q_r.s3;
    assign inter_conversion_pause = q_r.pause;
    assign result_channel_one = in_meas ? res[0] : '0;
    assign result_channel_two = in_meas ? res[1] : '0;
    assign result_channel_three = in_meas ? res[2] : '0;
    assign result_temp = in_meas ? q_r.temp : '0;
    assign status = q_r.stat;
    assign eoc_ready = q_r.ready;
    assign measure_state = in_meas;
    assign power_down = (q_r.st == csms_pkg::CSMS_ST_PDOWN);
endmodule
`default_nettype wire

/* verilog/csms_trig_sync.sv */
// trigger pin edge detector in the link clock domain, crossed by toggle
// assumes trig_clk runs while trigger edges may arrive
`timescale 1ns/1ps
`default_nettype none
module csms_trig_sync (
    input wire logic trig_clk,
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic external_trigger_pin,
    output logic fall_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic tog;
    } csms_lk_t;
    typedef struct packed {
        logic m1;
        logic m2;
        logic m3;
    } csms_mk_t;
    csms_lk_t lk_r, lk_nxt;
    csms_mk_t mk_r, mk_nxt;
    // ----------------------------------------
    // link side: sync, falling edge to toggle
    // ----------------------------------------
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.s1 = external_trigger_pin;
        lk_nxt.s2 = lk_r.s1;
        lk_nxt.s3 = lk_r.s2;
        if (lk_r.s3 && !lk_r.s2) begin
            lk_nxt.tog = ~lk_r.tog;
        end
    end
    always_ff @(posedge trig_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_r <= 4'hF;
        end else begin
            lk_r <= lk_nxt;
        end
    end
    // ----------------------------------------
    // main side: toggle to pulse
    // ----------------------------------------
    always_comb begin
        mk_nxt.m1 = lk_r.tog;
        mk_nxt.m2 = mk_r.m1;
        mk_nxt.m3 = mk_r.m2;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mk_r <= 3'h7;
        end else begin
            mk_r <= mk_nxt;
        end
    end
    assign fall_pulse = mk_r.m2 ^ mk_r.m3;
endmodule
`default_nettype wire
